// [common/mecg_pkg.sv]
// Summary of operation
// - read-only two-bit field reports register file check bits; 11 means seven bits.
// - read-only bit 27 tells software a memory error correction unit exists.
// - down-counter reloads programmed value; refresh every reload plus one clocks.
// - diagnostic write bypass set makes stores write test checkbits instead.
// - diagnostic read set copies fetched or loaded check bits into test field.
// - ram correction enable turns on check generation and checking for ram.
// - ram correction enable alone makes sub-word sdram stores read-modify-write.
// - prom correction enable at bit 8 turns on checking for prom accesses.
// - prom correction enable resets to zero, then loads general-purpose input line 2 on the third clock after reset.
// - eight-bit test checkbit field is software read/write, bypass source, capture target.
// - write guard checks only while enable bit 31 is set; resets to zero.
// - bit 30 selects mode: set is block-protect, clear is segment-allow.
// - fifteen-bit tag is exclusive-ORed with matching upper bits of each write address.
// - fifteen-bit mask selects which exclusive-OR result bits decide the match.
package mecg_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_MEM_CFG3 = 32'h8000_0008;
    localparam logic [31:0] ADDR_WGUARD1 = 32'h8000_001c;

    // memory_config_three field layout
    localparam int RFC_HI = 31;
    localparam int RFC_LO = 30;
    localparam int ECC_PRESENT_BIT = 27;
    localparam int RELOAD_HI = 26;
    localparam int RELOAD_LO = 12;
    localparam int WB_BIT = 11;
    localparam int RB_BIT = 10;
    localparam int RE_BIT = 9;
    localparam int PE_BIT = 8;
    localparam int TCB_HI = 7;
    localparam int TCB_LO = 0;

    // write_guard_one field layout
    localparam int WG_EN_BIT = 31;
    localparam int WG_BP_BIT = 30;
    localparam int WG_TAG_HI = 29;
    localparam int WG_TAG_LO = 15;
    localparam int WG_MASK_HI = 14;
    localparam int WG_MASK_LO = 0;
    localparam int ADDR_TAG_HI = 29;
    localparam int ADDR_TAG_LO = 15;

    // widths
    localparam int RELOAD_W = 15;
    localparam int TCB_W = 8;
    localparam int TAG_W = 15;

    // fixed and reset values
    localparam logic [1:0] RFC_SEVEN_BITS = 2'h3;
    localparam logic [RELOAD_W-1:0] RELOAD_RST = 15'h0000;
    localparam logic [TCB_W-1:0] TCB_RST = 8'h00;
    localparam logic [TAG_W-1:0] TAG_RST = 15'h0000;
    localparam logic [1:0] INIT_LOAD_CNT = 2'h2;

    // store request from the access sequencer
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic subword;
        logic to_sdram;
        logic [TCB_W-1:0] checkbits;
    } mecg_store_s;

    // decision returned for a store
    typedef struct packed {
        logic valid;
        logic allowed;
        logic rmw;
        logic [TCB_W-1:0] checkbits;
    } mecg_store_result_s;

    // check bits seen on a fetch or load
    typedef struct packed {
        logic valid;
        logic [TCB_W-1:0] checkbits;
    } mecg_load_s;

endpackage

// [rtl/mecg_refresh_timer.sv]
module mecg_refresh_timer #(
    parameter int WIDTH = mecg_pkg::RELOAD_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic [WIDTH-1:0] reload_in,
    output logic refresh_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_refresh;

    // count down, fire and reload at zero
    always_comb begin
        next_count = count;
        next_refresh = 1'b0;
        if (!enable_in) begin
            next_count = reload_in;
        end else if (count == '0) begin
            next_refresh = 1'b1;
            next_count = reload_in;
        end else begin
            next_count = count - 1'b1;
        end
    end

    // state registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count <= '0;
            refresh_out <= 1'b0;
        end else begin
            count <= next_count;
            refresh_out <= next_refresh;
        end
    end
endmodule

// [rtl/mecg_top.sv]
// Added by the designer: the strobed register port.
module mecg_top #(
    parameter logic MEM_ECC_PRESENT = 1'b1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [31:0] rdata_out,
    // strap pin
    input wire logic gpio2_in,
    // sdram controller side
    input wire logic sdram_enable_in,
    output logic refresh_cmd_out,
    // store and load traffic
    input wire mecg_pkg::mecg_store_s store_in,
    input wire mecg_pkg::mecg_load_s load_in,
    output mecg_pkg::mecg_store_result_s store_result_out,
    // protection enables to the access sequencer
    output logic ram_ecc_enable_out,
    output logic prom_ecc_enable_out,
    output logic sdram_subword_rmw_out
);

    // memory_config_three state
    logic [mecg_pkg::RELOAD_W-1:0] reload;
    logic [mecg_pkg::RELOAD_W-1:0] next_reload;
    logic diag_write_bypass;
    logic next_diag_write_bypass;
    logic diag_read_capture;
    logic next_diag_read_capture;
    logic ram_ecc_enable;
    logic next_ram_ecc_enable;
    logic prom_ecc_enable;
    logic next_prom_ecc_enable;
    logic [mecg_pkg::TCB_W-1:0] test_checkbits;
    logic [mecg_pkg::TCB_W-1:0] next_test_checkbits;

    // write_guard_one state
    logic guard_enable;
    logic next_guard_enable;
    logic block_protect_select;
    logic next_block_protect_select;
    logic [mecg_pkg::TAG_W-1:0] guard_tag;
    logic [mecg_pkg::TAG_W-1:0] next_guard_tag;
    logic [mecg_pkg::TAG_W-1:0] guard_mask;
    logic [mecg_pkg::TAG_W-1:0] next_guard_mask;

    // strap capture state
    logic gpio2_meta;
    logic gpio2_sync;
    logic [1:0] init_cnt;
    logic [1:0] next_init_cnt;

    // bus and result state
    logic [31:0] next_rdata;
    mecg_pkg::mecg_store_result_s next_store_result;
    logic next_ram_ecc_out;
    logic next_prom_ecc_out;
    logic next_rmw_out;

    // decode
    logic sel_cfg3;
    logic sel_guard;
    logic guard_permit;
    logic [31:0] cfg3_word;
    logic [31:0] guard_word;

    assign sel_cfg3 = (addr_in == mecg_pkg::ADDR_MEM_CFG3);
    assign sel_guard = (addr_in == mecg_pkg::ADDR_WGUARD1);

    // two-flop synchroniser for the strap pin
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gpio2_meta <= 1'b0;
            gpio2_sync <= 1'b0;
        end else begin
            gpio2_meta <= gpio2_in;
            gpio2_sync <= gpio2_meta;
        end
    end

    // read-back images of both registers
    always_comb begin
        cfg3_word = '0;
        cfg3_word[mecg_pkg::RFC_HI:mecg_pkg::RFC_LO] = mecg_pkg::RFC_SEVEN_BITS;
        cfg3_word[mecg_pkg::ECC_PRESENT_BIT] = MEM_ECC_PRESENT;
        cfg3_word[mecg_pkg::RELOAD_HI:mecg_pkg::RELOAD_LO] = reload;
        cfg3_word[mecg_pkg::WB_BIT] = diag_write_bypass;
        cfg3_word[mecg_pkg::RB_BIT] = diag_read_capture;
        cfg3_word[mecg_pkg::RE_BIT] = ram_ecc_enable;
        cfg3_word[mecg_pkg::PE_BIT] = prom_ecc_enable;
        cfg3_word[mecg_pkg::TCB_HI:mecg_pkg::TCB_LO] = test_checkbits;
        guard_word = '0;
        guard_word[mecg_pkg::WG_EN_BIT] = guard_enable;
        guard_word[mecg_pkg::WG_BP_BIT] = block_protect_select;
        guard_word[mecg_pkg::WG_TAG_HI:mecg_pkg::WG_TAG_LO] = guard_tag;
        guard_word[mecg_pkg::WG_MASK_HI:mecg_pkg::WG_MASK_LO] = guard_mask;
    end

    // next values of the configuration fields
    always_comb begin
        next_reload = reload;
        next_diag_write_bypass = diag_write_bypass;
        next_diag_read_capture = diag_read_capture;
        next_ram_ecc_enable = ram_ecc_enable;
        next_prom_ecc_enable = prom_ecc_enable;
        next_test_checkbits = test_checkbits;
        next_init_cnt = init_cnt;
        // strap load once the synchroniser output holds the pin level
        if (init_cnt != mecg_pkg::INIT_LOAD_CNT + 2'h1) begin
            next_init_cnt = init_cnt + 2'h1;
        end
        if (init_cnt == mecg_pkg::INIT_LOAD_CNT) begin
            next_prom_ecc_enable = gpio2_sync;
        end
        // software write
        if (write_in && sel_cfg3) begin
            next_reload = wdata_in[mecg_pkg::RELOAD_HI:mecg_pkg::RELOAD_LO];
            next_diag_write_bypass = wdata_in[mecg_pkg::WB_BIT];
            next_diag_read_capture = wdata_in[mecg_pkg::RB_BIT];
            next_ram_ecc_enable = wdata_in[mecg_pkg::RE_BIT];
            next_prom_ecc_enable = wdata_in[mecg_pkg::PE_BIT];
            next_test_checkbits = wdata_in[mecg_pkg::TCB_HI:mecg_pkg::TCB_LO];
        end
        // capture from a fetch or load beats a software write
        if (diag_read_capture && load_in.valid) begin
            next_test_checkbits = load_in.checkbits;
        end
    end

    // configuration registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reload <= mecg_pkg::RELOAD_RST;
            diag_write_bypass <= 1'b0;
            diag_read_capture <= 1'b0;
            ram_ecc_enable <= 1'b0;
            prom_ecc_enable <= 1'b0;
            test_checkbits <= mecg_pkg::TCB_RST;
            init_cnt <= 2'h0;
        end else begin
            reload <= next_reload;
            diag_write_bypass <= next_diag_write_bypass;
            diag_read_capture <= next_diag_read_capture;
            ram_ecc_enable <= next_ram_ecc_enable;
            prom_ecc_enable <= next_prom_ecc_enable;
            test_checkbits <= next_test_checkbits;
            init_cnt <= next_init_cnt;
        end
    end

    // next values of the write guard fields
    always_comb begin
        next_guard_enable = guard_enable;
        next_block_protect_select = block_protect_select;
        next_guard_tag = guard_tag;
        next_guard_mask = guard_mask;
        if (write_in && sel_guard) begin
            next_guard_enable = wdata_in[mecg_pkg::WG_EN_BIT];
            next_block_protect_select = wdata_in[mecg_pkg::WG_BP_BIT];
            next_guard_tag = wdata_in[mecg_pkg::WG_TAG_HI:mecg_pkg::WG_TAG_LO];
            next_guard_mask = wdata_in[mecg_pkg::WG_MASK_HI:mecg_pkg::WG_MASK_LO];
        end
    end

    // write guard registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            guard_enable <= 1'b0;
            block_protect_select <= 1'b0;
            guard_tag <= mecg_pkg::TAG_RST;
            guard_mask <= mecg_pkg::TAG_RST;
        end else begin
            guard_enable <= next_guard_enable;
            block_protect_select <= next_block_protect_select;
            guard_tag <= next_guard_tag;
            guard_mask <= next_guard_mask;
        end
    end

    // address compare against tag and mask
    mecg_write_guard #(
        .TAG_WIDTH(mecg_pkg::TAG_W)
    ) u_guard (
        .enable_in(guard_enable),
        .block_mode_in(block_protect_select),
        .tag_in(guard_tag),
        .mask_in(guard_mask),
        .addr_bits_in(store_in.addr[mecg_pkg::ADDR_TAG_HI:mecg_pkg::ADDR_TAG_LO]),
        .permit_out(guard_permit)
    );

    // refresh interval generator
    mecg_refresh_timer #(
        .WIDTH(mecg_pkg::RELOAD_W)
    ) u_refresh (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .enable_in(sdram_enable_in),
        .reload_in(reload),
        .refresh_out(refresh_cmd_out)
    );

    // store decision, check bit source and protection enables
    always_comb begin
        next_store_result.valid = store_in.valid;
        next_store_result.allowed = store_in.valid && guard_permit;
        next_store_result.rmw = store_in.valid && ram_ecc_enable
            && store_in.subword && store_in.to_sdram;
        if (diag_write_bypass) begin
            next_store_result.checkbits = test_checkbits;
        end else begin
            next_store_result.checkbits = store_in.checkbits;
        end
        next_ram_ecc_out = ram_ecc_enable;
        next_prom_ecc_out = prom_ecc_enable;
        next_rmw_out = ram_ecc_enable;
    end

    // read data mux, unmapped reads give zero
    always_comb begin
        next_rdata = '0;
        if (read_in && sel_cfg3) begin
            next_rdata = cfg3_word;
        end else if (read_in && sel_guard) begin
            next_rdata = guard_word;
        end
    end

    // output registers
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= '0;
            store_result_out <= '0;
            ram_ecc_enable_out <= 1'b0;
            prom_ecc_enable_out <= 1'b0;
            sdram_subword_rmw_out <= 1'b0;
        end else begin
            rdata_out <= next_rdata;
            store_result_out <= next_store_result;
            ram_ecc_enable_out <= next_ram_ecc_out;
            prom_ecc_enable_out <= next_prom_ecc_out;
            sdram_subword_rmw_out <= next_rmw_out;
        end
    end

endmodule

// [rtl/mecg_write_guard.sv]
module mecg_write_guard #(
    parameter int TAG_WIDTH = mecg_pkg::TAG_W
) (
    input wire logic enable_in,
    input wire logic block_mode_in,
    input wire logic [TAG_WIDTH-1:0] tag_in,
    input wire logic [TAG_WIDTH-1:0] mask_in,
    input wire logic [TAG_WIDTH-1:0] addr_bits_in,
    output logic permit_out
);
    logic [TAG_WIDTH-1:0] diff;
    logic match;

    // per-bit masked tag compare
    for (genvar i = 0; i < TAG_WIDTH; i++) begin : g_bit
        assign diff[i] = (tag_in[i] ^ addr_bits_in[i]) & mask_in[i];
    end

    // match and mode decision
    always_comb begin
        match = ~|diff;
        if (!enable_in) begin
            permit_out = 1'b1;
        end else if (block_mode_in) begin
            permit_out = !match;
        end else begin
            permit_out = match;
        end
    end
endmodule

// [tb/mecg_mem_model.sv]
module mecg_mem_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic fetch_in,
    input wire mecg_pkg::mecg_store_result_s result_in,
    output mecg_pkg::mecg_load_s load_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] stored;
    // one memory word: keeps written check bits, returns them on a fetch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            stored <= 8'h00; // memory holds valid contents before correction is on
            load_out <= '0;
        end else begin
            if (result_in.valid && result_in.allowed) begin
                stored <= result_in.checkbits;
            end
            load_out.valid <= fetch_in;
            load_out.checkbits <= fetch_in ? stored : ~load_out.checkbits; // no stale value
        end
    end
endmodule

// [tb/mecg_top_props.sv]
module mecg_top_props #(
    parameter logic MEM_ECC_PRESENT = 1'b1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [31:0] rdata_out,
    input wire logic sdram_enable_in,
    input wire logic refresh_cmd_out,
    input wire mecg_pkg::mecg_store_s store_in,
    input wire mecg_pkg::mecg_store_result_s store_result_out,
    input wire logic sdram_subword_rmw_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cfg;
    logic [31:0] wg;
    logic m;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // shadow copies of the two registers as software writes them
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cfg <= 32'h0000_0000;
            wg <= 32'h0000_0000;
        end else if (write_in && addr_in == mecg_pkg::ADDR_MEM_CFG3) begin
            cfg <= wdata_in;
        end else if (write_in && addr_in == mecg_pkg::ADDR_WGUARD1) begin
            wg <= wdata_in;
        end
    end
    // masked tag comparison of the current store
    assign m = ((wg[29:15] ^ store_in.addr[29:15]) & wg[14:0]) == 15'h0000;
    a_rfc_seven: assert property (read_in && addr_in == mecg_pkg::ADDR_MEM_CFG3 |=>
        rdata_out[31:30] == 2'h3) else $error("register file check field wrong");
    a_ecc_present: assert property (read_in && addr_in == mecg_pkg::ADDR_MEM_CFG3 |=>
        rdata_out[27] == MEM_ECC_PRESENT) else $error("memory ecc presence bit wrong");
    a_rmw_follows: assert property (store_in.valid |=> store_result_out.rmw ==
        (sdram_subword_rmw_out & $past(store_in.subword & store_in.to_sdram)))
        else $error("sub-word read-modify-write decision wrong");
    a_refresh_gap: assert property (refresh_cmd_out && cfg[26:12] == 15'h0003 &&
        $past(cfg[26:12]) == 15'h0003 ##1 sdram_enable_in [*4] |-> refresh_cmd_out &&
        !$past(refresh_cmd_out) && !$past(refresh_cmd_out, 2) && !$past(refresh_cmd_out, 3))
        else $error("refresh spacing wrong");
    a_refresh_off: assert property (!sdram_enable_in [*2] |-> !refresh_cmd_out)
        else $error("refresh while sdram disabled");
    a_guard_off: assert property (store_in.valid && !wg[31] |=> store_result_out.allowed)
        else $error("store blocked with guard disabled");
    a_guard_match: assert property (store_in.valid && wg[31] |=>
        store_result_out.allowed == ($past(wg[30]) ^ $past(m)))
        else $error("guard decision wrong");
    a_bypass_off: assert property (store_in.valid && !cfg[11] |=>
        store_result_out.checkbits == $past(store_in.checkbits))
        else $error("check bits replaced without bypass");
endmodule

bind mecg_top mecg_top_props #(.MEM_ECC_PRESENT(MEM_ECC_PRESENT)) mecg_top_props_inst (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .sdram_enable_in(sdram_enable_in), .refresh_cmd_out(refresh_cmd_out),
    .store_in(store_in), .store_result_out(store_result_out),
    .sdram_subword_rmw_out(sdram_subword_rmw_out));

// [tb/test_mem_edac_config_and_write_guard.sv]
module test_mem_edac_config_and_write_guard;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] wg; logic [31:0] addr; logic ok;} mecg_row_s;
    localparam logic [31:0] CFG = mecg_pkg::ADDR_MEM_CFG3;
    localparam logic [31:0] WG = mecg_pkg::ADDR_WGUARD1;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [31:0] addr_in = 32'h0000_0000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic gpio2_in = 1'b1;
    logic sdram_enable_in = 1'b0;
    logic fetch = 1'b0;
    logic [31:0] rdata_out;
    logic refresh_cmd_out;
    logic ram_ecc_enable_out;
    logic prom_ecc_enable_out;
    logic sdram_subword_rmw_out;
    mecg_pkg::mecg_store_s store_in = '0;
    mecg_pkg::mecg_load_s load_in;
    mecg_pkg::mecg_store_result_s store_result_out;
    int failures = 0;
    int compares = 0;
    int n;
    mecg_row_s rows [8] = '{'{32'h4000_ffff, 32'h0001_0000, 1'b1},
        '{32'h8000_ffff, 32'h0000_8000, 1'b1}, '{32'h8000_ffff, 32'h0001_0000, 1'b0},
        '{32'hc000_ffff, 32'h0000_8000, 1'b0}, '{32'hc000_ffff, 32'h0001_0000, 1'b1},
        '{32'h8000_8000, 32'h0001_0000, 1'b1}, '{32'h8000_8002, 32'h0001_0000, 1'b0},
        '{32'h8000_ffff, 32'hc000_8000, 1'b1}};
    mecg_top mecg_top_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
        .gpio2_in(gpio2_in), .sdram_enable_in(sdram_enable_in),
        .refresh_cmd_out(refresh_cmd_out), .store_in(store_in), .load_in(load_in),
        .store_result_out(store_result_out), .ram_ecc_enable_out(ram_ecc_enable_out),
        .prom_ecc_enable_out(prom_ecc_enable_out),
        .sdram_subword_rmw_out(sdram_subword_rmw_out));
    mecg_mem_model mecg_mem_model_inst (.clock_in(clock_in), .rst_in(rst_in),
        .fetch_in(fetch), .result_in(store_result_out), .load_out(load_in));
    // 40 mhz clock
    always #12.5 clock_in = ~clock_in;
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask
    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1;
        chk(name, rdata_out, exp);
    endtask
    task automatic st(input logic [31:0] a, input logic sub, input logic [7:0] cb);
        @(posedge clock_in);
        store_in <= '{valid: 1'b1, addr: a, subword: sub, to_sdram: 1'b1, checkbits: cb};
        @(posedge clock_in);
        store_in.valid <= 1'b0;
        #1;
    endtask
    task automatic fetch_word;
        @(posedge clock_in);
        fetch <= 1'b1;
        @(posedge clock_in);
        fetch <= 1'b0;
    endtask
    // bounded wait for the next refresh pulse, counting cycles
    task automatic next_pulse;
        n = 0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
        end while (refresh_cmd_out !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            conclude();
        end
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rd("cfg reset", CFG, 32'hc800_0100);
        rd("guard reset", WG, 32'h0000_0000);
        chk("prom out", prom_ecc_enable_out, 1'b1);
        wr(CFG, 32'hffff_ffff);
        rd("cfg ones", CFG, 32'hcfff_ffff);
        chk("ram out", ram_ecc_enable_out, 1'b1);
        wr(32'h8000_0010, 32'hffff_ffff);
        rd("unmapped", 32'h8000_0010, 32'h0000_0000);
        wr(CFG, 32'h0000_0000);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wr(WG, rows[i].wg);
            st(rows[i].addr, 1'b0, 8'h00);
            chk("allowed", store_result_out.allowed, rows[i].ok);
        end
        wr(WG, 32'h0000_0000);
        $display("test guard table done");
        wr(CFG, 32'h0000_0a5a); // ram correction and write bypass on, test check bits 5a
        st(32'h0000_0000, 1'b1, 8'h11);
        chk("bypass bits", store_result_out.checkbits, 8'h5a);
        chk("result valid", store_result_out.valid, 1'b1);
        chk("rmw sub", store_result_out.rmw, 1'b1);
        chk("ram out", ram_ecc_enable_out, 1'b1);
        st(32'h0000_0000, 1'b0, 8'h11);
        chk("rmw word", store_result_out.rmw, 1'b0);
        wr(CFG, 32'h0000_0400);
        st(32'h0000_0000, 1'b0, 8'h3c);
        chk("plain bits", store_result_out.checkbits, 8'h3c);
        fetch_word();
        rd("capture", CFG, 32'hc800_043c);
        wr(CFG, 32'h0000_0000);
        st(32'h0000_0000, 1'b0, 8'h77);
        fetch_word();
        rd("no capture", CFG, 32'hc800_0000);
        $display("test diagnostics done");
        wr(CFG, 32'h0000_3000);
        sdram_enable_in <= 1'b1;
        next_pulse();
        next_pulse();
        chk("refresh gap", n, 32'h0000_0004);
        sdram_enable_in <= 1'b0;
        n = 0;
        repeat (10) begin
            @(posedge clock_in);
            #1;
            n += refresh_cmd_out;
        end
        chk("refresh off", n, 32'h0000_0000);
        $display("test refresh done");
        @(posedge clock_in);
        rst_in <= 1'b1;
        gpio2_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
        chk("prom out low", prom_ecc_enable_out, 1'b0);
        rd("cfg strap low", CFG, 32'hc800_0000);
        $display("test second reset done");
        conclude();
    end
endmodule
